// [rtl/adcseq_top.sv]
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "adcseq_cfg.svh"
module adcseq_top
  import adcseq_pkg::*;
(
  input wire logic core_clk, // 125 MHz system clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic spiSclk, // SPI clock pin
  input wire logic spiCsN, // SPI chip select pin
  input wire logic spiSdi, // SPI data in pin
  output logic spiSdo, // SPI data out
  output logic spiSdoOe, // SPI data out enable
  input wire logic convertTrigger, // Conversion trigger pin
  input wire logic [15:0] convData, // Converter core result
  output logic convStart, // Converter core start pulse
  output logic resultReadyN, // Result ready, active low
  output logic frontendPowerEn // Front end power enable
);

  localparam int ConvCyc = `ADCSEQ_CONV_CYC;
  localparam logic [15:0] ConvLast = 16'(ConvCyc - 1);

  localparam adcseq_top_state_type RstState = '{
    mode: ST_CONFIG,
    avgField: `ADCSEQ_AVG_RST,
    warmCyc: `ADCSEQ_WARM_RST,
    timerCyc: `ADCSEQ_TIMER_RST,
    csSync: 3'h7,
    csLvl: 1'b1,
    rdyN: 1'b1,
    default: '0
  };

  adcseq_top_state_type q;
  adcseq_top_state_type d;
  adcseq_avg_if avgIf ();

  logic [1:0] trigStep;
  logic [1:0] csStep;
  logic [1:0] sclkStep;
  logic trigRise;
  logic csFall;
  logic sclkRise;
  logic sclkFall;
  logic adcActive;
  logic exitHit;
  logic ctrlWrite;
  logic [31:0] ctrlWord;
  logic [31:0] ctrlNew;
  logic [31:0] wordNew;
  logic [12:0] avgCount;
  logic [15:0] timerLoad;
  logic [4:0] shiftedIn;

  // Glitch-free edge: second and third synchroniser stages must agree
  function automatic logic [1:0] edgeStep(logic s2, logic s3, logic lvl);
    if (s2 == s3 && s3 != lvl)
      return {s3, 1'b1};
    return {lvl, 1'b0};
  endfunction

  function automatic logic [31:0] byteMerge(logic [31:0] old, logic [31:0] wd, logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    return res;
  endfunction

  function automatic logic isMapped(logic [11:0] a);
    return a == `ADCSEQ_OFF_CTRL || a == `ADCSEQ_OFF_AVG || a == `ADCSEQ_OFF_TIMER
      || a == `ADCSEQ_OFF_STATUS || a == `ADCSEQ_OFF_RESULT;
  endfunction

  always_comb
  begin
    ctrlWord = 32'h0000_0000;
    ctrlWord[`ADCSEQ_RUN_BIT] = q.run;
    ctrlWord[`ADCSEQ_MODE_LSB +: 2] = q.convMode;
    ctrlWord[`ADCSEQ_VARIANT_BIT] = q.variant;
    ctrlWord[`ADCSEQ_PWR_LSB +: 2] = q.pwr;
    ctrlWord[`ADCSEQ_FE_BIT] = q.feEn;
  end

  assign ctrlNew = byteMerge(ctrlWord, pwdata, pstrb);
  assign ctrlWrite = psel && penable && pwrite && paddr == `ADCSEQ_OFF_CTRL;
  // ratio field holds count minus one, floor of two
  assign avgCount = (q.avgField == 12'h000) ? `ADCSEQ_MIN_AVG : {1'b0, q.avgField} + 13'h0001;
  assign timerLoad = (q.timerCyc < 16'(ConvCyc)) ? ConvLast : q.timerCyc - 16'h0001;
  assign trigStep = edgeStep(q.trigSync[1], q.trigSync[2], q.trigLvl);
  assign csStep = edgeStep(q.csSync[1], q.csSync[2], q.csLvl);
  assign sclkStep = edgeStep(q.sclkSync[1], q.sclkSync[2], q.sclkLvl);
  assign trigRise = trigStep[0] && trigStep[1];
  assign csFall = csStep[0] && !csStep[1];
  assign sclkRise = sclkStep[0] && sclkStep[1] && !q.csLvl;
  assign sclkFall = sclkStep[0] && !sclkStep[1] && !q.csLvl;
  assign adcActive = q.mode != ST_CONFIG && q.mode != ST_SLEEP;
  assign shiftedIn = {q.inShift[3:0], q.sdiSync[2]};
  // exit pattern on the fifth rising SCLK of the frame
  assign exitHit = adcActive && sclkRise && q.bitCnt == `ADCSEQ_EXIT_LAST_BIT
    && shiftedIn == `ADCSEQ_EXIT_CODE;

  always_comb
  begin
    d = q;
    wordNew = 32'h0000_0000;
    d.convPulse = 1'b0;
    avgIf.clear = 1'b0;
    avgIf.addValid = 1'b0;
    d.trigSync = {q.trigSync[1:0], convertTrigger};
    d.csSync = {q.csSync[1:0], spiCsN};
    d.sclkSync = {q.sclkSync[1:0], spiSclk};
    d.sdiSync = {q.sdiSync[1:0], spiSdi};
    d.trigLvl = trigStep[1];
    d.csLvl = csStep[1];
    d.sclkLvl = sclkStep[1];

    // APB read data latched in the setup phase
    if (psel && !penable)
    begin
      case (paddr)
        `ADCSEQ_OFF_CTRL: d.prdata = ctrlWord;
        `ADCSEQ_OFF_AVG: d.prdata = {20'h0_0000, q.avgField};
        `ADCSEQ_OFF_TIMER: d.prdata = {q.timerCyc, q.warmCyc};
        `ADCSEQ_OFF_STATUS: d.prdata = {24'h00_0000, q.bitCnt, q.feOut, q.rdyN, q.mode};
        `ADCSEQ_OFF_RESULT: d.prdata = {q.avgResult[19:16] & {4{q.useAvg}},
          q.useAvg ? q.avgResult[15:0] : q.sample16, 12'h000};
        default: d.prdata = 32'h0000_0000;
      endcase
    end

    // APB writes
    if (ctrlWrite)
    begin
      d.run = ctrlNew[`ADCSEQ_RUN_BIT];
      d.convMode = ctrlNew[`ADCSEQ_MODE_LSB +: 2];
      d.variant = ctrlNew[`ADCSEQ_VARIANT_BIT];
      d.pwr = ctrlNew[`ADCSEQ_PWR_LSB +: 2];
      d.feEn = ctrlNew[`ADCSEQ_FE_BIT];
    end
    if (psel && penable && pwrite && paddr == `ADCSEQ_OFF_AVG)
    begin
      wordNew = byteMerge({20'h0_0000, q.avgField}, pwdata, pstrb);
      d.avgField = wordNew[11:0];
    end
    if (psel && penable && pwrite && paddr == `ADCSEQ_OFF_TIMER)
    begin
      wordNew = byteMerge({q.timerCyc, q.warmCyc}, pwdata, pstrb);
      d.warmCyc = wordNew[15:0];
      d.timerCyc = wordNew[`ADCSEQ_TIMER_PER_LSB +: 16];
    end

    // Averaged group finished
    if (avgIf.done)
    begin
      d.avgResult = avgIf.result;
      // ready low after a full group
      d.rdyN = 1'b0;
    end

    // Burst period timer runs from each conversion start
    if (q.timerCnt != 16'h0000)
      d.timerCnt = q.timerCnt - 16'h0001;

    case (q.mode)
      ST_CONFIG:
      begin
        // run written as one with power active
        if (ctrlWrite && ctrlNew[`ADCSEQ_RUN_BIT]
          && ctrlNew[`ADCSEQ_PWR_LSB +: 2] == `ADCSEQ_PWR_ACTIVE)
        begin
          // mode chosen from the fields as written
          d.mode = (ctrlNew[`ADCSEQ_MODE_LSB +: 2] == `ADCSEQ_MODE_AUTO) ? ST_AUTO : ST_IDLE;
          d.useAvg = ctrlNew[`ADCSEQ_MODE_LSB +: 2] != `ADCSEQ_MODE_SAMPLE;
          avgIf.clear = 1'b1;
        end
      end
      ST_SLEEP:
      begin
        if (q.pwr == `ADCSEQ_PWR_ACTIVE)
          d.mode = ST_CONFIG;
      end
      ST_IDLE:
      begin
        if (trigRise)
        begin
          if (q.convMode == `ADCSEQ_MODE_BURST)
            d.burstLeft = avgCount;
          d.feOut = q.feEn;
          // warmup delays the start when front end power is used
          if (q.feEn)
          begin
            d.mode = ST_WARMUP;
            d.phaseCnt = q.warmCyc;
          end
          else
          begin
            d.mode = ST_CONVERT;
            d.phaseCnt = ConvLast;
            d.convPulse = 1'b1;
            d.timerCnt = timerLoad;
            d.rdyN = (q.convMode == `ADCSEQ_MODE_SAMPLE) ? 1'b1 : q.rdyN;
          end
        end
      end
      ST_WARMUP:
      begin
        if (q.phaseCnt == 16'h0000)
        begin
          // conversion begins once warmup has elapsed
          d.mode = ST_CONVERT;
          d.phaseCnt = ConvLast;
          d.convPulse = 1'b1;
          d.timerCnt = timerLoad;
          d.rdyN = (q.convMode == `ADCSEQ_MODE_SAMPLE) ? 1'b1 : q.rdyN;
        end
        else
          d.phaseCnt = q.phaseCnt - 16'h0001;
      end
      ST_CONVERT:
      begin
        if (q.phaseCnt == 16'h0000)
        begin
          d.sample16 = convData;
          if (q.convMode == `ADCSEQ_MODE_SAMPLE)
          begin
            // ready low at end of a sample conversion
            d.rdyN = 1'b0;
            d.feOut = 1'b0;
            d.mode = ST_IDLE;
          end
          else
          begin
            // each result feeds the averaging filter
            avgIf.addValid = 1'b1;
            if (q.convMode == `ADCSEQ_MODE_BURST && q.burstLeft > 13'h0001)
            begin
              // further burst conversions one timer period apart
              d.burstLeft = q.burstLeft - 13'h0001;
              d.mode = ST_BURST_GAP;
            end
            else
            begin
              d.burstLeft = 13'h0000;
              d.feOut = 1'b0;
              d.mode = ST_IDLE;
            end
          end
        end
        else
          d.phaseCnt = q.phaseCnt - 16'h0001;
      end
      ST_BURST_GAP:
      begin
        // next start at the period mark keeps the latency exact
        if (q.timerCnt == 16'h0000)
        begin
          d.mode = ST_CONVERT;
          d.phaseCnt = ConvLast;
          d.convPulse = 1'b1;
          d.timerCnt = timerLoad;
        end
      end
      ST_AUTO:
      begin
        d.mode = ST_AUTO;
      end
      default:
      begin
        d.mode = ST_CONFIG;
      end
    endcase

    // Sleep overrides mode, front end power, start pulse and filter input; an exit in the same cycle still wins
    if (q.pwr == `ADCSEQ_PWR_SLEEP && q.mode != ST_SLEEP)
    begin
      d.mode = ST_SLEEP;
      d.feOut = 1'b0;
      d.convPulse = 1'b0;
      avgIf.addValid = 1'b0;
    end

    // SPI frame handling
    if (csFall)
    begin
      d.bitCnt = 3'h0;
      d.inShift = 5'h00;
      // averaged word carries four sign bits ahead of 20 bits
      d.outShift = q.useAvg ? {{4{q.avgResult[19]}}, q.avgResult} : {q.sample16, 8'h00};
    end
    if (sclkRise)
    begin
      d.inShift = shiftedIn;
      if (q.bitCnt < `ADCSEQ_EXIT_BITS)
        d.bitCnt = q.bitCnt + 3'h1;
    end
    // one result bit per falling SCLK; other frames just read
    if (sclkFall)
      d.outShift = {q.outShift[22:0], 1'b0};

    // exit clears run and returns to configuration
    if (exitHit)
    begin
      d.run = 1'b0;
      d.mode = ST_CONFIG;
      d.feOut = 1'b0;
      d.convPulse = 1'b0;
      d.burstLeft = 13'h0000;
      avgIf.clear = 1'b1;
      avgIf.addValid = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      q <= RstState;
    else if (ce)
      q <= d;
  end

  assign avgIf.sample = convData;
  assign avgIf.count = avgCount;

  adcseq_avg u_avg (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .avg(avgIf.accumulator)
  );

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !isMapped(paddr);
  assign spiSdo = q.outShift[23];
  assign spiSdoOe = !q.csLvl && adcActive;
  assign convStart = q.convPulse;
  assign resultReadyN = q.rdyN;
  assign frontendPowerEn = q.feOut;

  chk_reset_config: assert property (@(posedge core_clk)
    sys_rst |=> (q.mode == ST_CONFIG && !q.run)) else $error("not in config after reset");
  chk_sleep_select: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ce && q.pwr == `ADCSEQ_PWR_SLEEP && !exitHit) |=> q.mode == ST_SLEEP)
    else $error("sleep field ignored");
  chk_enter_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ce && q.mode == ST_CONFIG && q.pwr == `ADCSEQ_PWR_ACTIVE && ctrlWrite
    && ctrlNew[`ADCSEQ_RUN_BIT] && ctrlNew[`ADCSEQ_PWR_LSB +: 2] == `ADCSEQ_PWR_ACTIVE)
    |=> (q.mode == ST_IDLE || q.mode == ST_AUTO)) else $error("run write did not enter mode");
  chk_exit_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ce && exitHit) |=> (q.mode == ST_CONFIG && !q.run)) else $error("exit not taken");
  chk_warmup_first: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ce && q.mode == ST_IDLE && trigRise && q.feEn && q.pwr == `ADCSEQ_PWR_ACTIVE && !exitHit)
    |=> (q.mode == ST_WARMUP && q.feOut && !q.convPulse)) else $error("warmup skipped");
  chk_sample_ready: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ce && q.mode == ST_CONVERT && q.phaseCnt == 16'h0000 && q.pwr == `ADCSEQ_PWR_ACTIVE
    && q.convMode == `ADCSEQ_MODE_SAMPLE && !exitHit) |=> (!q.rdyN && q.mode == ST_IDLE))
    else $error("ready not low after sample");
  chk_burst_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (q.mode == ST_BURST_GAP && q.feEn) |-> q.feOut) else $error("enable dropped mid burst");
  chk_conv_length: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
    $rose(q.convPulse) |-> q.mode == ST_CONVERT && q.phaseCnt == ConvLast)
    else $error("conversion length wrong");
  chk_wake_config: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ce && q.mode == ST_SLEEP && q.pwr == `ADCSEQ_PWR_ACTIVE) |=> q.mode == ST_CONFIG)
    else $error("wake not to config");

endmodule

// [rtl/adcseq_cfg.svh]
`ifndef ADCSEQ_CFG_SVH
`define ADCSEQ_CFG_SVH

// Register byte offsets
`define ADCSEQ_OFF_CTRL 12'h000
`define ADCSEQ_OFF_AVG 12'h004
`define ADCSEQ_OFF_TIMER 12'h008
`define ADCSEQ_OFF_STATUS 12'h00C
`define ADCSEQ_OFF_RESULT 12'h010

// Control word and timer register field positions
`define ADCSEQ_RUN_BIT 0
`define ADCSEQ_MODE_LSB 1
`define ADCSEQ_VARIANT_BIT 3
`define ADCSEQ_PWR_LSB 4
`define ADCSEQ_FE_BIT 6
`define ADCSEQ_TIMER_PER_LSB 16

// Field encodings
`define ADCSEQ_MODE_SAMPLE 2'h0
`define ADCSEQ_MODE_BURST 2'h1
`define ADCSEQ_MODE_AVERAGE 2'h2
`define ADCSEQ_MODE_AUTO 2'h3
`define ADCSEQ_PWR_ACTIVE 2'h0
`define ADCSEQ_PWR_SLEEP 2'h3
`define ADCSEQ_EXIT_CODE 5'h15
`define ADCSEQ_EXIT_LAST_BIT 3'h4
`define ADCSEQ_EXIT_BITS 3'h5

// Reset values
`define ADCSEQ_AVG_RST 12'h00F
`define ADCSEQ_WARM_RST 16'h0040
`define ADCSEQ_TIMER_RST 16'h0080

// Timing
`define ADCSEQ_CLK_PERIOD_NS 8
`define ADCSEQ_CONV_TIME_NS 500
`define ADCSEQ_CONV_CYC ((`ADCSEQ_CONV_TIME_NS + `ADCSEQ_CLK_PERIOD_NS - 1) / `ADCSEQ_CLK_PERIOD_NS)
`define ADCSEQ_MIN_AVG 13'h0002

`endif

// [rtl/adcseq_pkg.sv]
package adcseq_pkg;

  typedef enum logic [2:0] {
    ST_CONFIG,
    ST_SLEEP,
    ST_IDLE,
    ST_WARMUP,
    ST_CONVERT,
    ST_BURST_GAP,
    ST_AUTO
  } adcseq_mode_type;

  typedef struct packed {
    adcseq_mode_type mode;
    logic run;
    logic [1:0] convMode;
    logic variant;
    logic [1:0] pwr;
    logic feEn;
    logic [11:0] avgField;
    logic [15:0] warmCyc;
    logic [15:0] timerCyc;
    logic [2:0] trigSync;
    logic trigLvl;
    logic [2:0] csSync;
    logic csLvl;
    logic [2:0] sclkSync;
    logic sclkLvl;
    logic [2:0] sdiSync;
    logic [15:0] phaseCnt;
    logic [15:0] timerCnt;
    logic [12:0] burstLeft;
    logic [15:0] sample16;
    logic [19:0] avgResult;
    logic useAvg;
    logic [4:0] inShift;
    logic [2:0] bitCnt;
    logic [23:0] outShift;
    logic [31:0] prdata;
    logic rdyN;
    logic feOut;
    logic convPulse;
  } adcseq_top_state_type;

  typedef struct packed {
    logic signed [28:0] sum;
    logic [12:0] cnt;
    logic [19:0] result;
    logic done;
  } adcseq_avg_state_type;

endpackage

// [rtl/adcseq_avg_if.sv]
`timescale 1ns/1ps
interface adcseq_avg_if;
  logic clear;
  logic addValid;
  logic [15:0] sample;
  logic [12:0] count;
  logic done;
  logic [19:0] result;

  modport sequencer (output clear, output addValid, output sample, output count,
    input done, input result);
  modport accumulator (input clear, input addValid, input sample, input count,
    output done, output result);
endinterface

// [rtl/adcseq_avg.sv]
`timescale 1ns/1ps
`include "adcseq_cfg.svh"
module adcseq_avg
  import adcseq_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic ce, // Clock enable
  adcseq_avg_if.accumulator avg // Accumulator port
);

  adcseq_avg_state_type q;
  adcseq_avg_state_type d;
  logic signed [28:0] newSum;
  logic signed [32:0] scaled;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    newSum = q.sum + 29'(signed'(avg.sample));
    scaled = signed'({newSum, 4'h0}) / signed'({20'h0_0000, avg.count});
    if (avg.clear)
    begin
      d.sum = '0;
      d.cnt = '0;
    end
    else if (avg.addValid)
    begin
      if (q.cnt + 13'h0001 >= avg.count)
      begin
        // group complete, next group starts empty
        d.result = scaled[19:0];
        d.done = 1'b1;
        d.sum = '0;
        d.cnt = '0;
      end
      else
      begin
        d.sum = newSum;
        d.cnt = q.cnt + 13'h0001;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign avg.done = q.done;
  assign avg.result = q.result;

  chk_avg_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
    q.done |-> (q.cnt == 13'h0000 && q.sum == 29'sh0)) else $error("accumulator not restarted");
  chk_avg_group: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ce && !avg.clear && avg.addValid && q.cnt + 13'h0001 < avg.count) |=> !q.done)
    else $error("averaged result before group complete");

endmodule

// [tb/adcseq_host_model.sv]
`timescale 1ns/1ps
module adcseq_host_model
(
  input wire logic core_clk, // System clock
  output logic spiSclk, // SPI clock, still between frames
  output logic spiCsN, // SPI select, active low
  output logic spiSdi, // SPI data to device
  input wire logic spiSdo, // SPI data from device
  output logic convertTrigger // Conversion trigger pin
);
  initial
  begin
    spiSclk = 1'b0;
    spiCsN = 1'b1;
    spiSdi = 1'b0;
    convertTrigger = 1'b0;
  end

  // Half link period, 80 ns
  task automatic half();
    repeat (10) @(posedge core_clk);
  endtask

  task automatic trigger();
    half();
    convertTrigger <= 1'b1;
    half();
    convertTrigger <= 1'b0;
  endtask

  task automatic frame(input logic [23:0] sdiWord, input int nBits, output logic [23:0] got);
    got = 24'h00_0000;
    @(posedge core_clk);
    spiCsN <= 1'b0;
    for (int i = nBits - 1; i >= 0; i--)
    begin
      spiSdi <= sdiWord[i];
      half();
      spiSclk <= 1'b1;
      got = {got[22:0], spiSdo};
      half();
      spiSclk <= 1'b0;
    end
    half();
    spiCsN <= 1'b1;
    spiSdi <= ~spiSdi;
    half();
  endtask
endmodule

// [tb/adcseq_top_bench.sv]
`timescale 1ns/1ps
`include "adcseq_cfg.svh"
module adcseq_top_bench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] convData = 16'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, spiSclk, spiCsN, spiSdi, spiSdo, spiSdoOe;
  logic convertTrigger, convStart, resultReadyN, frontendPowerEn;
  logic [6:0] ctrlTab [5] = '{7'h01, 7'h03, 7'h05, 7'h07, 7'h0F};
  logic [2:0] modeTab [5] = '{3'h2, 3'h2, 3'h2, 3'h6, 3'h6};
  int failures = 0;
  int nCompared = 0;
  int convCount = 0;
  int seed = 32'he4c36be7;
  int base, lat;
  time tRise, tStart;
  logic [31:0] rd;
  logic [23:0] got;
  logic err;
  logic [15:0] q[$];

  initial
  begin
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge convertTrigger) tRise = $time;

  always @(posedge core_clk)
  begin
    if (convStart === 1'b1)
    begin
      convCount <= convCount + 1;
      tStart <= $time;
    end
  end

  adcseq_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .spiSclk(spiSclk),
    .spiCsN(spiCsN), .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe),
    .convertTrigger(convertTrigger), .convData(convData), .convStart(convStart),
    .resultReadyN(resultReadyN), .frontendPowerEn(frontendPowerEn));

  adcseq_host_model host (.core_clk(core_clk), .spiSclk(spiSclk), .spiCsN(spiCsN),
    .spiSdi(spiSdi), .spiSdo(spiSdo), .convertTrigger(convertTrigger));

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    nCompared++;
    if (seen !== want)
    begin
      failures++;
      $display("[ERR] %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
    begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask

  // host waits for ready before reading
  task automatic wait_ready();
    int n;
    n = 0;
    while (resultReadyN !== 1'b0 && n < 3000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    lat = int'(($time - tRise) / 8);
  endtask

  // Averaged word: four sign bits then the 20-bit mean
  function automatic logic [23:0] avg_word();
    int s;
    s = 0;
    foreach (q[i]) s += int'($signed(q[i]));
    return 24'(s * 16 / q.size());
  endfunction

  task automatic new_sample();
    @(posedge core_clk);
    convData <= 16'($random(seed));
    @(posedge core_clk);
    q.push_back(convData);
  endtask

  task automatic report_and_stop();
    $display("compared %0d failures %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    do_reset();
    check({resultReadyN, frontendPowerEn, spiSdoOe}, 3'b100, "reset pins");
    apb(0, `ADCSEQ_OFF_STATUS, 0);
    check(rd[2:0], 3'h0, "reset mode");
    apb(0, 12'h0FC, 0);
    check(err, 1'b1, "unmapped");
    for (int i = 0; i < 5; i++)
    begin
      apb(1, `ADCSEQ_OFF_CTRL, ctrlTab[i] & 7'h7E);
      apb(1, `ADCSEQ_OFF_CTRL, ctrlTab[i]);
      apb(0, `ADCSEQ_OFF_STATUS, 0);
      check(rd[2:0], modeTab[i], "mode entry");
      host.frame(24'h00_0015, 5, got);
      apb(0, `ADCSEQ_OFF_CTRL, 0);
      check(rd[0], 1'b0, "run cleared");
      apb(0, `ADCSEQ_OFF_STATUS, 0);
      check(rd[2:0], 3'h0, "exit mode");
    end
    apb(1, `ADCSEQ_OFF_AVG, 12'h123);
    apb(1, `ADCSEQ_OFF_CTRL, 7'h31);
    apb(0, `ADCSEQ_OFF_STATUS, 0);
    check(rd[2:0], 3'h1, "sleep");
    apb(1, `ADCSEQ_OFF_CTRL, 7'h00);
    apb(0, `ADCSEQ_OFF_STATUS, 0);
    check(rd[2:0], 3'h0, "wake");
    apb(0, `ADCSEQ_OFF_AVG, 0);
    check(rd[11:0], 12'h123, "kept");
    // Sample mode with front end warmup of 16 cycles
    apb(1, `ADCSEQ_OFF_TIMER, 32'h0000_0010);
    apb(1, `ADCSEQ_OFF_CTRL, 7'h41);
    new_sample();
    base = convCount;
    host.trigger();
    wait_ready();
    check(int'((tStart - tRise) / 8) inside {[17:23]}, 1'b1, "warmup");
    check(convCount - base, 1, "one conv");
    // Pulse monitor sees the start one edge after it is launched
    check(int'(($time - tStart) / 8) + 1, `ADCSEQ_CONV_CYC, "conv time");
    check(frontendPowerEn, 1'b0, "fe off");
    fork
      host.frame(24'h00_0000, 16, got);
      begin
        repeat (30) @(posedge core_clk);
        check(spiSdoOe, 1'b1, "sdo enable");
      end
    join
    check(got[15:0], q[0], "sample");
    // Averaging by two, two groups
    do_reset();
    apb(1, `ADCSEQ_OFF_AVG, 12'h001);
    apb(1, `ADCSEQ_OFF_CTRL, 7'h05);
    for (int g = 0; g < 2; g++)
    begin
      q.delete();
      for (int k = 0; k < 2; k++)
      begin
        new_sample();
        host.trigger();
        repeat (80) @(posedge core_clk);
        if (g == 0)
        begin
          check(resultReadyN, k == 0, "avg ready");
        end
      end
      host.frame(24'h00_0000, 24, got);
      check(got, avg_word(), "avg word");
    end
    // Burst of two with front end
    do_reset();
    apb(1, `ADCSEQ_OFF_AVG, 12'h001);
    apb(1, `ADCSEQ_OFF_TIMER, 32'h0000_0010);
    apb(1, `ADCSEQ_OFF_CTRL, 7'h43);
    q.delete();
    new_sample();
    q.push_back(q[0]);
    base = convCount;
    host.trigger();
    check(frontendPowerEn, 1'b1, "fe on");
    wait_ready();
    check(lat inside {[144:154]}, 1'b1, "burst latency");
    check(convCount - base, 2, "burst count");
    check(frontendPowerEn, 1'b0, "fe end");
    host.frame(24'h00_0000, 24, got);
    check(got, avg_word(), "burst word");
    report_and_stop();
  end
endmodule
